// ==== verilog/rols_top.sv ====
// Top of the relay output line supervisor with Wishbone register slave
// Functional notes
// - Common block waits settling interval after supply
// - Module healthy is AND of channel health
// - One common block, one block per channel
// - Channels use delayed supply, not raw monitor
// - Relay follows command, forced off by short
// - Short readback sets the short flag
// - Lead break or blown fuse sets lead flag
// - Output on with relay off is mismatch
// - Output low with relay on is mismatch
// - Channel healthy only with no line faults
// - Relays map to outputs 1-7 or 17-23
// - Readbacks from analog inputs 9-15 or 25-31
// - Readback decoded into five current classes
// - Supply presence from digital input 16 or 32
`timescale 1ns/1ps
`default_nettype none
module rols_top
  import rols_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Field side
  input wire logic [1:0] monitored_digital_input_in,
  input wire logic [NUM_AI*RB_W-1:0] analog_input_in,
  output logic [DO_W-1:0] discrete_output_out,
  output logic module_healthy_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  // Control register: commanded values and half select
  logic [31:0] ctrl_ff;
  // Interrupt status and mask
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic irq_ff;
  // Bus answer
  logic ack_ff;
  logic [31:0] rdata_ff;
  // Pin synchronisers, first stage read only by second
  logic [1:0] dil_meta_ff;
  logic [1:0] dil_sync_ff;
  logic [NUM_AI*RB_W-1:0] ai_meta_ff;
  logic [NUM_AI*RB_W-1:0] ai_sync_ff;
  // Registered discrete outputs
  logic [DO_W-1:0] do_ff;
  // Previous flag values for edge events
  logic [NUM_CH-1:0] short_d_ff;
  logic [NUM_CH-1:0] lead_d_ff;
  logic [NUM_CH-1:0] mism_d_ff;
  logic mod_ok_d_ff;
  logic settled_d_ff;
  // Channel results
  logic [NUM_CH-1:0] relay_w;
  logic [NUM_CH-1:0] short_w;
  logic [NUM_CH-1:0] lead_w;
  logic [NUM_CH-1:0] mism_w;
  logic [NUM_CH-1:0] healthy_w;
  logic [RB_W-1:0] rb_w [NUM_CH];
  // Common block results
  logic supply_settled_w;
  logic module_ok_w;

  ////////////////////////////////////////////////////////////////
  // Control decode

  // Alternate half selects outputs 17-23, inputs 25-31 and 32
  wire alt_half = ctrl_ff[CTRL_ALT_BIT];
  wire [NUM_CH-1:0] cmd_w = ctrl_ff[NUM_CH-1:0];
  // supply presence from selected monitored input
  wire supply_raw = alt_half ? dil_sync_ff[1] : dil_sync_ff[0];

  ////////////////////////////////////////////////////////////////
  // Input synchronisers

  // Two stages on every pin input before any logic
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      dil_meta_ff <= 2'h0;
      dil_sync_ff <= 2'h0;
    end else begin
      dil_meta_ff <= monitored_digital_input_in;
      dil_sync_ff <= dil_meta_ff;
    end
  end

  // Readback words: the converter holds them steady between samples,
  // so a plain two-stage path is acceptable; a word caught mid-change
  // lasts one cycle and at worst gives one cycle of a wrong class.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ai_meta_ff <= '0;
      ai_sync_ff <= '0;
    end else begin
      ai_meta_ff <= analog_input_in;
      ai_sync_ff <= ai_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Common block

  rols_common #(
    .SETTLE_CYCLES(SETTLE_CYCLES)
  ) u_common (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .supply_monitor_in(supply_raw),
    .channel_healthy_in({1'b1, healthy_w}),
    .field_supply_present_out(supply_settled_w),
    .module_healthy_out(module_ok_w)
  );

  ////////////////////////////////////////////////////////////////
  // Channel blocks

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // readback from analog input 9+i or 25+i
      assign rb_w[gi] = alt_half ? ai_sync_ff[(gi+NUM_CH)*RB_W +: RB_W] : ai_sync_ff[gi*RB_W +: RB_W];
      rols_channel u_ch (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        // delayed supply from the common block
        .field_supply_present_in(supply_settled_w),
        .commanded_value_in(cmd_w[gi]),
        .channel_readback_in(rb_w[gi]),
        .relay_drive_out(relay_w[gi]),
        .short_out(short_w[gi]),
        .lead_break_out(lead_w[gi]),
        .mismatch_out(mism_w[gi]),
        .channel_healthy_out(healthy_w[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////
  // Discrete output mapping

  // relays onto outputs 1-7 or 17-23
  wire [DO_W-1:0] do_low = {{(DO_W-NUM_CH){1'b0}}, relay_w};
  wire [DO_W-1:0] do_high = do_low << ALT_DO_BASE;
  wire [DO_W-1:0] nxt_do = alt_half ? do_high : do_low;

  // Extra stage so the pins come straight from a flop
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      do_ff <= '0;
    end else begin
      do_ff <= nxt_do;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Wishbone decode

  wire bus_req = wb_cyc_in & wb_stb_in & ~ack_ff;
  wire wr_en = bus_req & wb_we_in;
  wire hit_ctrl = (wb_adr_in == ADDR_CTRL);
  wire hit_chstat = (wb_adr_in == ADDR_CHSTAT);
  wire hit_modstat = (wb_adr_in == ADDR_MODSTAT);
  wire hit_irqstat = (wb_adr_in == ADDR_IRQSTAT);
  wire hit_irqmask = (wb_adr_in == ADDR_IRQMASK);
  // Byte lane mask built from sel
  wire [31:0] lane_mask = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
  // Writable control bits only
  wire [31:0] ctrl_wmask = 32'h0000_017f;
  wire [31:0] nxt_ctrl = (ctrl_ff & ~(lane_mask & ctrl_wmask)) | (wb_dat_in & lane_mask & ctrl_wmask);
  wire [IRQ_W-1:0] irq_wr = wb_dat_in[IRQ_W-1:0] & {IRQ_W{wb_sel_in[0]}};
  // Channel status word
  wire [31:0] chstat_w = {1'b0, mism_w, 1'b0, lead_w, 1'b0, short_w, 1'b0, healthy_w};
  // Module status: raw supply, settled, module healthy
  wire [31:0] modstat_w = {29'h0, module_ok_w, supply_settled_w, supply_raw};
  // Unmapped addresses read zero and ignore writes
  wire [31:0] rd_mux = hit_ctrl ? ctrl_ff :
                       hit_chstat ? chstat_w :
                       hit_modstat ? modstat_w :
                       hit_irqstat ? {27'h0, irq_stat_ff} :
                       hit_irqmask ? {27'h0, irq_mask_ff} :
                       32'h0000_0000;

  ////////////////////////////////////////////////////////////////
  // Bus answer: ack one cycle after the request

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff <= bus_req;
      // Hold read data stable until next request
      if (bus_req) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // Control register write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_ff <= CTRL_RST;
    end else if (wr_en && hit_ctrl) begin
      ctrl_ff <= nxt_ctrl;
    end
  end

  // Mask register write
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_mask_ff <= IRQ_RST;
    end else if (wr_en && hit_irqmask && wb_sel_in[0]) begin
      irq_mask_ff <= wb_dat_in[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////
  // Events and interrupt

  // Rising edges of any channel short, lead or mismatch flag, module health loss, settling done
  wire [IRQ_W-1:0] evt_w = {
    supply_settled_w & ~settled_d_ff,
    ~module_ok_w & mod_ok_d_ff,
    |(mism_w & ~mism_d_ff),
    |(lead_w & ~lead_d_ff),
    |(short_w & ~short_d_ff)
  };
  // Write one to clear; a new event wins over the clear
  wire [IRQ_W-1:0] clr_w = (wr_en && hit_irqstat) ? irq_wr : {IRQ_W{1'b0}};
  wire [IRQ_W-1:0] nxt_irq_stat = (irq_stat_ff & ~clr_w) | evt_w;

  // Edge history
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      short_d_ff <= '0;
      lead_d_ff <= '0;
      mism_d_ff <= '0;
      mod_ok_d_ff <= 1'b0;
      settled_d_ff <= 1'b0;
    end else begin
      short_d_ff <= short_w;
      lead_d_ff <= lead_w;
      mism_d_ff <= mism_w;
      mod_ok_d_ff <= module_ok_w;
      settled_d_ff <= supply_settled_w;
    end
  end

  // Sticky status and level output
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_ff <= IRQ_RST;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= nxt_irq_stat;
      irq_ff <= |(nxt_irq_stat & irq_mask_ff);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdata_ff;
  assign discrete_output_out = do_ff;
  // Module flag is a flop inside the common block
  assign module_healthy_out = module_ok_w;
  assign irq_out = irq_ff;

  ////////////////////////////////////////////////////////////////
  // Checks

  map_low_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !alt_half |=> (do_ff[NUM_CH-1:0] == $past(relay_w) && do_ff[DO_W-1:ALT_DO_BASE] == '0))
    else $error("low half output mapping wrong");
  map_high_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    alt_half |=> (do_ff[ALT_DO_BASE +: NUM_CH] == $past(relay_w) && do_ff[NUM_CH-1:0] == '0))
    else $error("high half output mapping wrong");
  bus_ack_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (wb_cyc_in && wb_stb_in && !ack_ff) |=> ack_ff ##1 !ack_ff)
    else $error("ack not a single cycle after request");
  irq_level_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    irq_ff == |(irq_stat_ff & $past(irq_mask_ff)))
    else $error("interrupt level wrong");
  unsettled_pins_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !supply_settled_w |=> ##1 (do_ff == '0)) else $error("output driven while unsettled");
  spare_tie_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (supply_settled_w && &healthy_w) |=> module_ok_w) else $error("spare input pulls health low");
endmodule : rols_top
`default_nettype wire

// ==== verilog/rols_pkg.sv ====
// Shared constants, classes and register map of the relay output line supervisor
`default_nettype none
package rols_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned SETTLE_MS = 2000;
  localparam int unsigned SETTLE_CYC = SETTLE_MS * (CLK_HZ / 1000);
  // Channel counts
  localparam int unsigned NUM_CH = 7;
  localparam int unsigned AND_W = 8;
  localparam int unsigned NUM_AI = 14;
  localparam int unsigned RB_W = 8;
  localparam int unsigned DO_W = 24;
  localparam int unsigned ALT_DO_BASE = 16;
  // Readback class bounds in 0.1 mA steps, +/- 1 mA around each level
  localparam logic [7:0] LB_LO = 8'h28;
  localparam logic [7:0] OC_LO = 8'h3c;
  localparam logic [7:0] CC_LO = 8'h50;
  localparam logic [7:0] SC_LO = 8'h64;
  localparam logic [7:0] SC_HI = 8'h78;
  // Readback classes
  typedef enum logic [2:0] {
    CLS_LEAD_BREAK = 3'b000,
    CLS_OPEN = 3'b001,
    CLS_CLOSED = 3'b010,
    CLS_SHORT = 3'b011,
    CLS_FAULT = 3'b100
  } rols_class_e;
  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CHSTAT = 8'h04;
  localparam logic [7:0] ADDR_MODSTAT = 8'h08;
  localparam logic [7:0] ADDR_IRQSTAT = 8'h0c;
  localparam logic [7:0] ADDR_IRQMASK = 8'h10;
  // Field positions
  localparam int unsigned CTRL_ALT_BIT = 8;
  localparam int unsigned CH_SHORT_POS = 8;
  localparam int unsigned CH_LEAD_POS = 16;
  localparam int unsigned CH_MISM_POS = 24;
  localparam int unsigned IRQ_SHORT = 0;
  localparam int unsigned IRQ_LEAD = 1;
  localparam int unsigned IRQ_MISM = 2;
  localparam int unsigned IRQ_MODLOST = 3;
  localparam int unsigned IRQ_READY = 4;
  localparam int unsigned IRQ_W = 5;
  // Reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;

  // Readback current to class
  function automatic rols_class_e rols_decode(input logic [7:0] code);
    rols_class_e cls;
    if (code >= LB_LO && code < OC_LO) begin
      cls = CLS_LEAD_BREAK;
    end else if (code >= OC_LO && code < CC_LO) begin
      cls = CLS_OPEN;
    end else if (code >= CC_LO && code < SC_LO) begin
      cls = CLS_CLOSED;
    end else if (code >= SC_LO && code <= SC_HI) begin
      cls = CLS_SHORT;
    end else begin
      cls = CLS_FAULT;
    end
    return cls;
  endfunction : rols_decode
endpackage : rols_pkg
`default_nettype wire

// ==== verilog/rols_common.sv ====
// Common block: supply settling delay and module health AND
`timescale 1ns/1ps
`default_nettype none
module rols_common
  import rols_pkg::*;
#(
  parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
) (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic supply_monitor_in,
  input wire logic [AND_W-1:0] channel_healthy_in,
  output logic field_supply_present_out,
  output logic module_healthy_out
);
  logic [31:0] settle_cnt_ff; // Cycles since supply seen
  logic settled_ff; // Delayed supply indication
  logic module_ok_ff; // Registered AND result
  wire settle_end = (settle_cnt_ff == 32'(SETTLE_CYCLES - 1));
  // AND over channels, spares come in tied high
  wire all_ok = &channel_healthy_in;

  ////////////////////////////////////////////////////////////////
  // settling hold-off
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      settle_cnt_ff <= 32'h0000_0000;
      settled_ff <= 1'b0;
    end else if (!supply_monitor_in) begin
      // Any supply drop restarts the wait
      settle_cnt_ff <= 32'h0000_0000;
      settled_ff <= 1'b0;
    end else if (!settled_ff) begin
      settle_cnt_ff <= settle_cnt_ff + 32'h0000_0001;
      settled_ff <= settle_end;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      module_ok_ff <= 1'b0;
    end else begin
      module_ok_ff <= settled_ff & all_ok;
    end
  end

  assign field_supply_present_out = settled_ff;
  assign module_healthy_out = module_ok_ff;

  ////////////////////////////////////////////////////////////////
  supply_drop_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !supply_monitor_in |=> !settled_ff) else $error("settled flag survived supply loss");
  settle_wait_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(settled_ff) |-> $past(settle_end)) else $error("settled before interval elapsed");
  module_and_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    module_ok_ff == $past(settled_ff && all_ok)) else $error("module health differs from AND");
endmodule : rols_common
`default_nettype wire

// ==== verilog/rols_channel.sv ====
// Channel block: relay drive and readback fault flags
`timescale 1ns/1ps
`default_nettype none
module rols_channel
  import rols_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire logic field_supply_present_in,
  input wire logic commanded_value_in,
  input wire logic [RB_W-1:0] channel_readback_in,
  output logic relay_drive_out,
  output logic short_out,
  output logic lead_break_out,
  output logic mismatch_out,
  output logic channel_healthy_out
);
  logic relay_ff, short_ff, lead_ff, mism_ff, healthy_ff;
  rols_class_e cls;
  assign cls = rols_decode(channel_readback_in);
  wire is_short = (cls == CLS_SHORT);
  // Blown fuse reads as lead break too
  wire is_lead = (cls == CLS_LEAD_BREAK);
  // on while relay off, low while relay on, or readback out of range
  wire is_mism = ((cls == CLS_CLOSED) & ~relay_ff) | ((cls == CLS_OPEN) & relay_ff) | (cls == CLS_FAULT);
  wire pwr = field_supply_present_in;
  wire nxt_relay = pwr & commanded_value_in & ~is_short;

  ////////////////////////////////////////////////////////////////
  // short blocks relay, off while unsettled
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      relay_ff <= 1'b0;
      short_ff <= 1'b0;
      lead_ff <= 1'b0;
      mism_ff <= 1'b0;
      healthy_ff <= 1'b0;
    end else begin
      relay_ff <= nxt_relay;
      short_ff <= pwr & is_short;
      lead_ff <= pwr & is_lead;
      mism_ff <= pwr & is_mism;
      healthy_ff <= pwr & ~is_short & ~is_lead & ~is_mism;
    end
  end

  assign relay_drive_out = relay_ff;
  assign short_out = short_ff;
  assign lead_break_out = lead_ff;
  assign mismatch_out = mism_ff;
  assign channel_healthy_out = healthy_ff;

  ////////////////////////////////////////////////////////////////
  short_blocks_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    short_ff |-> !relay_ff) else $error("relay energized during short");
  short_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pwr && cls == CLS_SHORT) |=> short_ff) else $error("short not flagged");
  lead_flag_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pwr && cls == CLS_LEAD_BREAK) |=> lead_ff) else $error("lead break not flagged");
  mism_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pwr && cls == CLS_CLOSED && !relay_ff) |=> mism_ff) else $error("on while off not flagged");
  mism_on_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pwr && cls == CLS_OPEN && relay_ff) |=> mism_ff) else $error("low while on not flagged");
  health_clear_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    healthy_ff |-> !(short_ff || lead_ff || mism_ff)) else $error("healthy with a fault");
  unsettled_off_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !pwr |=> !(relay_ff || short_ff || lead_ff || mism_ff || healthy_ff)) else $error("active while unsettled");
  relay_cmd_a: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (pwr && commanded_value_in && !is_short) |=> relay_ff) else $error("relay ignores command");
endmodule : rols_channel
`default_nettype wire

// ==== verilog/rols_pkg_dummy_guard.sv ====
// Intentionally empty marker file
`default_nettype none
`default_nettype wire

// ==== bench/rols_field_model.sv ====
// Field side model: readback circuits and supply monitor of the termination module
`timescale 1ns/1ps
`default_nettype none
module rols_field_model
  import rols_pkg::*;
(
  input wire logic [DO_W-1:0] relay_in,
  input wire logic alt_in,
  input wire logic supply_on_in,
  input wire logic [NUM_CH*3-1:0] mode_in,
  output logic [1:0] supply_mon_out,
  output logic [NUM_AI*RB_W-1:0] readback_out
);
  //////////////////////////////////////////////////////////////////////////////
  // Modes 0, 6 and 7 follow the relay, modes 1-5 inject a fixed line state
  function automatic logic [7:0] code(input logic [2:0] m, input logic on);
    case (m)
      3'h1: code = 8'h6e; // Short, 11 mA
      3'h2: code = 8'h32; // Lead break, 5 mA
      3'h3: code = 8'h5a; // Stuck closed, 9 mA
      3'h4: code = 8'h46; // Stuck open, 7 mA
      3'h5: code = 8'h0a; // Out of range
      default: code = on ? 8'h5a : 8'h46;
    endcase
  endfunction : code
  // five current classes
  // Idle half reads out of range, never a stale code
  always_comb begin
    readback_out = {(NUM_AI*RB_W){1'b1}};
    for (int c = 0; c < NUM_CH; c++) begin
      readback_out[(c + (alt_in ? NUM_CH : 0))*RB_W +: RB_W] =
        code(mode_in[3*c +: 3], relay_in[c + (alt_in ? ALT_DO_BASE : 0)]);
    end
  end
  assign supply_mon_out = alt_in ? {supply_on_in, 1'b0} : {1'b0, supply_on_in};
endmodule : rols_field_model
`default_nettype wire

// ==== bench/rols_tb_top.sv ====
// Self-checking testbench of the relay output line supervisor
`timescale 1ns/1ps
`default_nettype none
module rols_tb_top;
  import rols_pkg::*;
  localparam int unsigned SETTLE = 16; // Short settling for simulation
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0] wb_adr = 8'h00;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_wdat = 32'h0, wb_rdat, rd;
  logic [1:0] mon;
  logic [NUM_AI*RB_W-1:0] ai;
  logic [DO_W-1:0] dout;
  logic mod_ok, irq;
  logic alt = 1'b0, sup = 1'b0; // Half select and field supply
  logic [NUM_CH*3-1:0] modes = '0; // Injected line state per channel
  logic [6:0] cmd;
  int fails = 0, checks_done = 0;
  int seed = 32'hc125ca40;
  //////////////////////////////////////////////////////////////////////////////
  // Clock and instances
  always #20 clk_sys_in = ~clk_sys_in;
  rols_top #(.SETTLE_CYCLES(SETTLE)) u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .monitored_digital_input_in(mon), .analog_input_in(ai),
    .discrete_output_out(dout), .module_healthy_out(mod_ok), .irq_out(irq));
  rols_field_model u_field (.relay_in(dout), .alt_in(alt), .supply_on_in(sup), .mode_in(modes),
    .supply_mon_out(mon), .readback_out(ai));
  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  // Classic single cycle; entered just after a rising edge, waits for ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_wdat <= d;
    wb_sel <= 4'hf;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    q = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    if (wb_ack !== 1'b1) begin
      fails++;
      $display("[FAIL] %0t bus acknowledge timed out", $time);
      give_verdict();
    end
    @(posedge clk_sys_in);
  endtask : wb
  // Reference: expected status, relays and module health from injected modes
  task automatic expect_all();
    logic [31:0] st;
    logic [DO_W-1:0] dx;
    logic r;
    int m;
    st = '0;
    dx = '0;
    for (int i = 0; i < NUM_CH; i++) begin
      m = modes[3*i +: 3];
      r = cmd[i] && m != 1;
      dx[i + (alt ? ALT_DO_BASE : 0)] = r;
      st[CH_SHORT_POS+i] = (m == 1);
      st[CH_LEAD_POS+i] = (m == 2);
      st[CH_MISM_POS+i] = (m == 5) || (m == 3 && !r) || (m == 4 && r);
      st[i] = (m == 0) || (m == 3 && r) || (m == 4 && !r);
    end
    wb(1'b0, ADDR_CHSTAT, 32'h0, rd);
    chk(rd, st, "channel status");
    chk(32'(dout), 32'(dx), "relay pins");
    chk(32'(mod_ok), 32'(&st[6:0]), "module health");
  endtask : expect_all
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    sup <= 1'b1;
    cmd = 7'h7f;
    // Commands issued while settling must not reach the relays
    wb(1'b1, ADDR_CTRL, 32'h7f, rd);
    repeat (6) @(posedge clk_sys_in);
    chk(32'(dout), 32'h0, "relays while settling");
    wb(1'b0, ADDR_MODSTAT, 32'h0, rd);
    chk(rd, 32'h1, "settling status");
    repeat (SETTLE + 8) @(posedge clk_sys_in);
    wb(1'b0, ADDR_MODSTAT, 32'h0, rd);
    chk(rd, 32'h7, "settled status");
    expect_all();
    $display("test settle done");
    // Random commands and line states, last rounds on the alternate half
    for (int t = 0; t < 14; t++) begin
      cmd = 7'($random(seed));
      alt <= (t >= 9);
      for (int i = 0; i < NUM_CH; i++) modes[3*i +: 3] <= 3'(($random(seed) & 32'h7fff) % 6);
      wb(1'b1, ADDR_CTRL, {23'h0, t >= 9, 1'b0, cmd}, rd);
      // Moving to the other half swaps supply monitor inputs, so settling restarts
      repeat ((t == 9) ? SETTLE + 12 : 10) @(posedge clk_sys_in);
      expect_all();
    end
    $display("test channels done");
    // Interrupt: clear, raise by a short, unmask, clear
    modes <= '0;
    cmd = 7'h00;
    wb(1'b1, ADDR_CTRL, 32'h100, rd);
    repeat (10) @(posedge clk_sys_in);
    wb(1'b1, ADDR_IRQSTAT, 32'h1f, rd);
    wb(1'b0, ADDR_IRQSTAT, 32'h0, rd);
    chk(rd, 32'h0, "status cleared");
    modes <= 21'h1;
    repeat (10) @(posedge clk_sys_in);
    wb(1'b0, ADDR_IRQSTAT, 32'h0, rd);
    chk(rd, 32'h9, "short and health events");
    chk(32'(irq), 32'h0, "masked interrupt");
    wb(1'b1, ADDR_IRQMASK, 32'h1, rd);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h1, "unmasked interrupt");
    wb(1'b1, ADDR_IRQSTAT, 32'h1, rd);
    repeat (2) @(posedge clk_sys_in);
    chk(32'(irq), 32'h0, "interrupt cleared");
    wb(1'b0, 8'h14, 32'h0, rd);
    chk(rd, 32'h0, "unmapped read");
    $display("test interrupt done");
    // Supply loss drops relays and health within six cycles
    modes <= '0;
    cmd = 7'h7f;
    wb(1'b1, ADDR_CTRL, 32'h17f, rd);
    repeat (10) @(posedge clk_sys_in);
    expect_all();
    sup <= 1'b0;
    repeat (6) @(posedge clk_sys_in);
    chk(32'(dout), 32'h0, "relays after supply loss");
    chk(32'(mod_ok), 32'h0, "health after supply loss");
    $display("test supply loss done");
    give_verdict();
  end
endmodule : rols_tb_top
`default_nettype wire
